// [rtl/uic_top.sv]
// Interrupt ranking, masking and FIFO control for one UART channel
// Notes on behaviour
// - FIFO off, low enables clear: polled
// - Line status bits report receive/transmit state
// - Receive ready at data or trigger
// - Transmit ready; immediate if already empty
// - Overrun immediate; errors at readout/arrival
// - Modem status interrupt from delta bits
// - Upper enables writable only when enhanced
// - Rising flow-control pins interrupt when enabled
// - Timeout after four chars twelve bits
// - Transmit source set; RS-485 uses all-empty in FIFO mode
// - Xoff or special match flag
// - Wake indication reads as none, INTERRUPT_SOURCE_CODE-cleared
// - Fixed seven-level identification code table
// - Only highest pending source is reported
// - Top ID bits mirror FIFO enable
// - Flow-control flag gated by its enables
// - Per-source clearing on register accesses
// - Xoff, special, flow-control clearing events
// - FIFO enable bit gates rest of write
// - FIFO reset bits pulse, self-clear
// - DMA mode select bit
// - Modem control bit enables interrupt pin
`timescale 1ns/10ps
`default_nettype none
module uic_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       efr_enh,
  input  wire logic       extended_modem_status_reg_err_now,
  input  wire logic       mcr_irq_en,
  input  wire logic       auto_cts_en,
  input  wire logic       auto_rts_en,
  input  wire logic       rs485_en,
  input  wire logic       rx_present,
  input  wire logic       rx_at_trig,
  input  wire logic       rx_char_evt,
  input  wire logic       overrun_evt,
  input  wire logic       err_arrive_evt,
  input  wire logic       err_readout_evt,
  input  wire logic       overrun_flag,
  input  wire logic [2:0] head_err,
  input  wire logic       fifo_err_any,
  input  wire logic       thr_empty,
  input  wire logic       tx_all_empty,
  input  wire logic       tx_below_trig,
  input  wire logic       tx_fifo_empty,
  input  wire logic [3:0] msr_delta,
  input  wire logic       cts_n_in,
  input  wire logic       rts_n_out,
  input  wire logic       xoff_match,
  input  wire logic       xon_match,
  input  wire logic       special_match,
  input  wire logic       wake_evt,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  output logic            irq_out,
  output logic            irq_oe,
  output logic            fifo_enable,
  output logic            dma_mode,
  output logic            rx_fifo_rst,
  output logic            tx_fifo_rst,
  output logic            sleep_en
);
  import uic_pkg::*;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] interrupt_enable_mask;
    logic       fifo_en;
    logic       dma;
    logic       rx_rst;
    logic       tx_rst;
    logic       lsr_p;
    logic       rxto_p;
    logic       thr_p;
    logic       msr_p;
    logic       xoff_p;
    logic       spc_p;
    logic       cts_p;
    logic       rts_p;
    logic       wake_p;
    logic       tx_prev;
    logic       cts_prev;
    logic       rts_prev;
    logic       irq;
    uic_acc_t   acc;
    logic [7:0] rdata;
  } uic_state_t;

  uic_state_t       q;
  uic_state_t       d;
  logic             rd_go;
  logic             wr_go;
  logic             ier_wr;
  logic             fcr_wr;
  logic             thr_wr;
  logic             isr_rd;
  logic             lsr_rd;
  logic             msr_rd;
  logic             rhr_rd;
  logic             tx_cond;
  logic             rx_rdy;
  logic             to_fire;
  logic [NSRC-1:0]  act;
  logic [NSRC-1:0]  sel;
  logic [5:0]       code;
  logic [7:0]       lsr_val;
  // ---------------------------------------------------------------
  // Access decode, effects fire once at strobe start
  // ---------------------------------------------------------------
  assign rd_go  = (q.acc == ACC_IDLE) && !cs_n && !rd_n;
  assign wr_go  = (q.acc == ACC_IDLE) && !cs_n && rd_n && !wr_n;
  assign ier_wr = wr_go && (addr == OFS_IER);
  assign fcr_wr = wr_go && (addr == OFS_ISR);
  assign thr_wr = wr_go && (addr == OFS_RHR);
  assign isr_rd = rd_go && (addr == OFS_ISR);
  assign lsr_rd = rd_go && (addr == OFS_LSR);
  assign msr_rd = rd_go && (addr == OFS_MSR);
  assign rhr_rd = rd_go && (addr == OFS_RHR);
  // ---------------------------------------------------------------
  // Source conditions
  // ---------------------------------------------------------------
  // line status byte layout
  assign lsr_val = {fifo_err_any, tx_all_empty, thr_empty, head_err, overrun_flag, rx_present};
  assign rx_rdy  = q.fifo_en ? rx_at_trig : rx_present;
  assign tx_cond = q.fifo_en ? (rs485_en ? tx_all_empty : (tx_below_trig | tx_fifo_empty))
                             : thr_empty;
  assign act[SRC_LSR]  = q.lsr_p & q.interrupt_enable_mask[IER_LSR];
  assign act[SRC_RXTO] = q.rxto_p & q.interrupt_enable_mask[IER_RX];
  assign act[SRC_RXRD] = rx_rdy & q.interrupt_enable_mask[IER_RX];
  assign act[SRC_THR]  = q.thr_p & q.interrupt_enable_mask[IER_THR];
  assign act[SRC_MSR]  = q.msr_p & q.interrupt_enable_mask[IER_MSR];
  // Xoff or special gated by enable
  assign act[SRC_XOFF] = (q.xoff_p | q.spc_p) & q.interrupt_enable_mask[IER_XOFF];
  assign act[SRC_FC]   = (q.cts_p & q.interrupt_enable_mask[IER_CTS]) | (q.rts_p & q.interrupt_enable_mask[IER_RTS]);

  uic_prio_enc #(
    .N (NSRC)
  ) u_prio (
    .pend (act),
    .code (code),
    .sel  (sel)
  );

  uic_rx_timeout #(
    .CNT_W (8)
  ) u_to (
    .clk       (clk),
    .nrst      (nrst),
    .bit_tick  (bit_tick),
    .char_bits (char_bits),
    .nonempty  (q.fifo_en & rx_present),
    .restart   (rx_char_evt | rhr_rd),
    .fire      (to_fire)
  );
  // ---------------------------------------------------------------
  // Next state: clears first, then sets, so an event always wins
  // ---------------------------------------------------------------
  always_comb begin
    d          = q;
    d.rx_rst   = 1'b0;
    d.tx_rst   = 1'b0;
    d.tx_prev  = tx_cond;
    d.cts_prev = cts_n_in;
    d.rts_prev = rts_n_out;
    unique case (q.acc)
      ACC_IDLE: begin
        if (rd_go) begin
          d.acc = ACC_READ;
        end else if (wr_go) begin
          d.acc = ACC_WRITE;
        end
      end
      ACC_READ: begin
        if (cs_n || rd_n) begin
          d.acc = ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (cs_n || wr_n) begin
          d.acc = ACC_IDLE;
        end
      end
      default: d.acc = ACC_IDLE;
    endcase
    // Read data frozen for the whole strobe
    if (rd_go) begin
      unique case (addr)
        OFS_IER: d.rdata = q.interrupt_enable_mask;
        // FIFO status in the top bits
        OFS_ISR: d.rdata = {q.fifo_en, q.fifo_en, code};
        OFS_LSR: d.rdata = lsr_val;
        default: d.rdata = 8'h00;
      endcase
    end
    if (ier_wr) begin
      d.interrupt_enable_mask[3:0] = wdata[3:0];
      if (efr_enh) begin
        d.interrupt_enable_mask[7:4] = wdata[7:4];
      end
    end
    // bit 0 is always written and gates the rest of the write
    if (fcr_wr) begin
      d.fifo_en = wdata[FCR_EN];
      if (wdata[FCR_EN]) begin
        d.dma    = wdata[FCR_DMA];
        d.rx_rst = wdata[FCR_RXRST];
        d.tx_rst = wdata[FCR_TXRST];
      end
    end
    if (lsr_rd) begin
      d.lsr_p = 1'b0;
    end
    if (rhr_rd) begin
      d.rxto_p = 1'b0;
    end
    if (thr_wr || (isr_rd && sel[SRC_THR])) begin
      d.thr_p = 1'b0;
    end
    // flow-control sources clear on modem read
    if (msr_rd) begin
      d.msr_p = 1'b0;
      d.cts_p = 1'b0;
      d.rts_p = 1'b0;
    end
    if (xon_match || (isr_rd && sel[SRC_XOFF])) begin
      d.xoff_p = 1'b0;
    end
    if (rx_char_evt || (isr_rd && sel[SRC_XOFF])) begin
      d.spc_p = 1'b0;
    end
    // wake indication cleared by INTERRUPT_SOURCE_CODE read
    if (isr_rd) begin
      d.wake_p = 1'b0;
    end
    if (overrun_evt || (extended_modem_status_reg_err_now ? err_arrive_evt : err_readout_evt)) begin
      d.lsr_p = 1'b1;
    end
    if (to_fire) begin
      d.rxto_p = 1'b1;
    end
    if ((tx_cond && !q.tx_prev) || (ier_wr && wdata[IER_THR] && !q.interrupt_enable_mask[IER_THR] && tx_cond)) begin
      d.thr_p = 1'b1;
    end
    if (|msr_delta) begin
      d.msr_p = 1'b1;
    end
    if (xoff_match) begin
      d.xoff_p = 1'b1;
    end
    if (special_match) begin
      d.spc_p = 1'b1;
    end
    // rising pin under auto flow control
    if (auto_cts_en && cts_n_in && !q.cts_prev) begin
      d.cts_p = 1'b1;
    end
    if (auto_rts_en && rts_n_out && !q.rts_prev) begin
      d.rts_p = 1'b1;
    end
    if (wake_evt) begin
      d.wake_p = 1'b1;
    end
    // follows pending sources, one cycle late
    d.irq = (|act) | q.wake_p;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q          <= '0;
      q.interrupt_enable_mask      <= IER_RST;
      q.tx_prev  <= 1'b1;
      q.cts_prev <= 1'b1;
      q.rts_prev <= 1'b1;
      q.acc      <= ACC_IDLE;
    end else begin
      q <= d;
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata       = q.rdata;
  assign irq_out     = q.irq;
  assign irq_oe      = mcr_irq_en;
  assign fifo_enable = q.fifo_en;
  assign dma_mode    = q.dma;
  assign rx_fifo_rst = q.rx_rst;
  assign tx_fifo_rst = q.tx_rst;
  assign sleep_en    = q.interrupt_enable_mask[IER_SLEEP];
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_isr_fifo_bits;
    @(posedge clk) disable iff (!nrst)
    isr_rd |=> rdata[7:6] == {2{$past(q.fifo_en)}} && rdata[5:0] == $past(code);
  endproperty
  a_isr_fifo_bits: assert property (p_isr_fifo_bits) else $error("INTERRUPT_SOURCE_CODE top bits wrong");

  property p_ier_lock;
    @(posedge clk) disable iff (!nrst)
    (ier_wr && !efr_enh) |=> q.interrupt_enable_mask[7:4] == $past(q.interrupt_enable_mask[7:4]) && q.interrupt_enable_mask[3:0] == $past(wdata[3:0]);
  endproperty
  a_ier_lock: assert property (p_ier_lock) else $error("locked enables changed");

  property p_fcr_ignore;
    @(posedge clk) disable iff (!nrst)
    (fcr_wr && !wdata[FCR_EN]) |=> !q.fifo_en && q.dma == $past(q.dma) && !q.rx_rst && !q.tx_rst;
  endproperty
  a_fcr_ignore: assert property (p_fcr_ignore) else $error("FIFO write not ignored");

  property p_rx_rst_pulse;
    @(posedge clk) disable iff (!nrst)
    (fcr_wr && wdata[FCR_EN] && wdata[FCR_RXRST]) |=> rx_fifo_rst ##1 !rx_fifo_rst;
  endproperty
  a_rx_rst_pulse: assert property (p_rx_rst_pulse) else $error("reset pulse not one cycle");

  property p_lsr_clear;
    @(posedge clk) disable iff (!nrst)
    (lsr_rd && !overrun_evt && !err_arrive_evt && !err_readout_evt) |=> !q.lsr_p;
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("line status not cleared");

  property p_thr_arm;
    @(posedge clk) disable iff (!nrst)
    (ier_wr && wdata[IER_THR] && !q.interrupt_enable_mask[IER_THR] && tx_cond) |=> act[SRC_THR] ##1 irq_out;
  endproperty
  a_thr_arm: assert property (p_thr_arm) else $error("no immediate transmit ready");

  property p_xon_clear;
    @(posedge clk) disable iff (!nrst)
    (xon_match && !xoff_match) |=> !q.xoff_p;
  endproperty
  a_xon_clear: assert property (p_xon_clear) else $error("Xoff not cleared by Xon");

  property p_irq_idle;
    @(posedge clk) disable iff (!nrst)
    (code == CODE_NONE && !q.wake_p) |=> !irq_out;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt held without source");

  property p_lsr_top;
    @(posedge clk) disable iff (!nrst)
    act[SRC_LSR] |-> code == CODE_LSR && sel == 7'h01;
  endproperty
  a_lsr_top: assert property (p_lsr_top) else $error("line status not top priority");
endmodule // uic_top
`default_nettype wire

// [common/uic_pkg.sv]
// Constants shared by the UART interrupt and FIFO control block
package uic_pkg;
  // ---------------------------------------------------------------
  // Register offsets on the parallel host bus
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_RHR = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_ISR = 3'h2;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int IER_RX    = 0;
  localparam int IER_THR   = 1;
  localparam int IER_LSR   = 2;
  localparam int IER_MSR   = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF  = 5;
  localparam int IER_RTS   = 6;
  localparam int IER_CTS   = 7;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA   = 3;
  localparam logic [7:0] IER_RST = 8'h00;
  // ---------------------------------------------------------------
  // Identification codes, index 0 is the highest priority
  // ---------------------------------------------------------------
  localparam int NSRC = 7;
  localparam logic [5:0] CODE_LSR  = 6'h06;
  localparam logic [5:0] CODE_RXTO = 6'h0c;
  localparam logic [5:0] CODE_RXRD = 6'h04;
  localparam logic [5:0] CODE_THR  = 6'h02;
  localparam logic [5:0] CODE_MSR  = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FC   = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam logic [5:0] CODES [NSRC] = '{CODE_LSR, CODE_RXTO, CODE_RXRD,
                                         CODE_THR, CODE_MSR, CODE_XOFF, CODE_FC};
  localparam int SRC_LSR  = 0;
  localparam int SRC_RXTO = 1;
  localparam int SRC_RXRD = 2;
  localparam int SRC_THR  = 3;
  localparam int SRC_MSR  = 4;
  localparam int SRC_XOFF = 5;
  localparam int SRC_FC   = 6;
  // ---------------------------------------------------------------
  // Receive timeout in character and bit times
  // ---------------------------------------------------------------
  localparam int TO_CHARS = 4;
  localparam int TO_BITS  = 12;
  // ---------------------------------------------------------------
  // Host access tracker
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'h1,
    ACC_READ  = 3'h2,
    ACC_WRITE = 3'h4
  } uic_acc_t;
endpackage

// [rtl/uic_prio_enc.sv]
// Priority encoder from pending sources to identification code
`timescale 1ns/10ps
`default_nettype none
module uic_prio_enc #(
  parameter int N = 7
) (
  input  wire logic [N-1:0] pend,
  output logic      [5:0]   code,
  output logic      [N-1:0] sel
);
  import uic_pkg::*;
  if (N != NSRC) begin : g_chk
    $error("uic_prio_enc: N must match the code table");
  end
  // ---------------------------------------------------------------
  // Lowest priority first so the highest one overwrites
  // ---------------------------------------------------------------
  always_comb begin
    code = CODE_NONE;
    sel  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        code   = CODES[i];
        sel    = '0;
        sel[i] = 1'b1;
      end
    end
  end
endmodule // uic_prio_enc
`default_nettype wire

// [rtl/uic_rx_timeout.sv]
// Receive timeout timer counted in bit-time ticks
`timescale 1ns/10ps
`default_nettype none
module uic_rx_timeout #(
  parameter int CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  input  wire logic       nonempty,
  input  wire logic       restart,
  output logic            fire
);
  import uic_pkg::*;
  if (CNT_W < 7) begin : g_chk
    $error("uic_rx_timeout: CNT_W too small for the longest delay");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             armed;
  } uic_to_t;
  uic_to_t          q;
  uic_to_t          d;
  logic [CNT_W-1:0] lim;

  function automatic logic [CNT_W-1:0] to_limit(input logic [3:0] bits);
    to_limit = CNT_W'(TO_CHARS * int'(bits) + TO_BITS);
  endfunction

  assign lim = to_limit(char_bits);
  // ---------------------------------------------------------------
  // Counter, one shot per quiet period
  // ---------------------------------------------------------------
  always_comb begin
    d    = q;
    fire = 1'b0;
    if (restart || !nonempty) begin
      d.cnt   = '0;
      d.armed = nonempty;
    end else if (bit_tick && q.armed) begin
      if (q.cnt == lim - CNT_W'(1)) begin
        fire    = 1'b1;
        d.armed = 1'b0;
        d.cnt   = '0;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  property p_fire_cause;
    @(posedge clk) disable iff (!nrst)
    fire |-> nonempty && !restart && bit_tick && $past(d.cnt) == lim - CNT_W'(1);
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("timeout fired without cause");
endmodule // uic_rx_timeout
`default_nettype wire

// [verification/uic_host.sv]
// Host processor model driving the parallel register bus
`timescale 1ns/10ps
`default_nettype none
module uic_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [2:0] addr,
  output logic      [7:0] wdata
);
  initial begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    addr  = 3'h0;
    wdata = 8'h00;
  end
  // One access: held across the taking edge, released, then read data taken
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    cs_n  = 1'b0;
    rd_n  = w;
    wr_n  = !w;
    addr  = a;
    wdata = d;
    @(posedge clk);
    @(negedge clk);
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    // Released lines flip so a stale value never looks valid
    addr  = ~addr;
    wdata = ~wdata;
    @(negedge clk);
    q = rdata;
  endtask
endmodule // uic_host
`default_nettype wire

// [verification/uic_top_tb.sv]
// Self-checking testbench for the interrupt and FIFO control block
`timescale 1ns/10ps
`default_nettype none
module uic_top_tb;
  import uic_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, cs_n, rd_n, wr_n, irq_out, irq_oe, fifo_enable;
  logic dma_mode, rx_fifo_rst, tx_fifo_rst, sleep_en, bit_tick = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q;
  logic efr_enh = 1'b0, extended_modem_status_reg_err_now = 1'b0, mcr_irq_en = 1'b0, auto_cts_en = 1'b0;
  logic auto_rts_en = 1'b0, rs485_en = 1'b0, rx_present = 1'b0, rx_at_trig = 1'b0;
  logic rx_char_evt = 1'b0, overrun_evt = 1'b0, err_arrive_evt = 1'b0;
  logic err_readout_evt = 1'b0, overrun_flag = 1'b0, fifo_err_any = 1'b0;
  logic thr_empty = 1'b0, tx_all_empty = 1'b0, tx_below_trig = 1'b0;
  logic tx_fifo_empty = 1'b0, cts_n_in = 1'b0, rts_n_out = 1'b0, xoff_match = 1'b0;
  logic xon_match = 1'b0, special_match = 1'b0, wake_evt = 1'b0;
  logic [2:0] head_err = 3'h0;
  logic [3:0] msr_delta = 4'h0;
  logic [3:0] char_bits = 4'ha;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] fw [5] = '{8'h06, 8'h07, 8'h0b, 8'h08, 8'h01};
  // Expected {fifo_enable, dma_mode, reset pulse count}
  logic [3:0] fx [5] = '{4'h0, 4'ha, 4'hd, 4'h4, 4'h8};
  int err_total = 0;
  int n_compared = 0;
  int n_rst = 0;
  int n0;

  uic_top DUT (.*);
  uic_host host (.clk(clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
                 .addr(addr), .wdata(wdata));

  initial begin
    forever #12.5 clk = ~clk;
  end
  // Bit time every four clocks keeps the timeout short
  always @(negedge clk) begin
    tdiv <= tdiv + 2'h1;
    bit_tick <= (tdiv == 2'h3);
  end
  // Pulses sampled mid-cycle, away from the edge that launches them
  always @(negedge clk) n_rst <= n_rst + int'(rx_fifo_rst) + int'(tx_fifo_rst);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [2:0] a, input string nm, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    cyc(6);
    nrst = 1'b1;
    rd(OFS_ISR, "isr", 8'h01);
    rd(OFS_IER, "ier", IER_RST);
    rx_present = 1'b1;
    overrun_flag = 1'b1;
    head_err = 3'h5;
    fifo_err_any = 1'b1;
    thr_empty = 1'b1;
    rd(OFS_LSR, "lsr", 8'hb7);
    rx_present = 1'b0;
    overrun_flag = 1'b0;
    head_err = 3'h0;
    fifo_err_any = 1'b0;
    for (int i = 0; i < 5; i++) begin
      n0 = n_rst;
      wr(OFS_ISR, fw[i]);
      chk("fifo_enable", {7'h0, fx[i][3]}, {7'h0, fifo_enable});
      chk("dma_mode", {7'h0, fx[i][2]}, {7'h0, dma_mode});
      chk("fifo_rst", {6'h0, fx[i][1:0]}, 8'(n_rst - n0));
    end
    rd(OFS_ISR, "isr", 8'hc1);
    wr(OFS_IER, 8'hf0);
    rd(OFS_IER, "ier", 8'h00);
    efr_enh = 1'b1;
    wr(OFS_IER, 8'h10);
    rd(OFS_IER, "ier", 8'h10);
    chk("sleep_en", 8'h01, {7'h0, sleep_en});
    tx_fifo_empty = 1'b1;
    mcr_irq_en = 1'b1;
    wr(OFS_IER, 8'h02);
    cyc(2);
    chk("irq_oe", 8'h01, {7'h0, irq_oe});
    chk("irq_out", 8'h01, {7'h0, irq_out});
    rd(OFS_ISR, "isr", 8'hc2);
    rd(OFS_ISR, "isr", 8'hc1);
    chk("irq_out", 8'h00, {7'h0, irq_out});
    mcr_irq_en = 1'b0;
    chk("irq_oe", 8'h00, {7'h0, irq_oe});
    wr(OFS_IER, 8'h01);
    rx_at_trig = 1'b1;
    rd(OFS_ISR, "isr", 8'hc4);
    rx_at_trig = 1'b0;
    rd(OFS_ISR, "isr", 8'hc1);
    wr(OFS_IER, 8'h0f);
    overrun_evt = 1'b1;
    msr_delta = 4'h1;
    cyc(1);
    overrun_evt = 1'b0;
    msr_delta = 4'h0;
    rd(OFS_ISR, "isr", 8'hc6);
    rd(OFS_LSR, "lsr", 8'h20);
    rd(OFS_ISR, "isr", 8'hc2);
    rd(OFS_ISR, "isr", 8'hc0);
    rd(OFS_MSR, "msr", 8'h00);
    rd(OFS_ISR, "isr", 8'hc1);
    wr(OFS_IER, 8'h01);
    rx_present = 1'b1;
    rx_char_evt = 1'b1;
    cyc(1);
    rx_char_evt = 1'b0;
    // Fires after 52 bit times of 4 clocks each
    cyc(140);
    rd(OFS_ISR, "isr", 8'hc1);
    cyc(120);
    rd(OFS_ISR, "isr", 8'hcc);
    rd(OFS_RHR, "rhr", 8'h00);
    rx_present = 1'b0;
    rd(OFS_ISR, "isr", 8'hc1);
    auto_cts_en = 1'b1;
    wr(OFS_IER, 8'ha0);
    xoff_match = 1'b1;
    cyc(1);
    xoff_match = 1'b0;
    rd(OFS_ISR, "isr", 8'hd0);
    rd(OFS_ISR, "isr", 8'hc1);
    cts_n_in = 1'b1;
    rd(OFS_ISR, "isr", 8'he0);
    rd(OFS_MSR, "msr", 8'h00);
    rd(OFS_ISR, "isr", 8'hc1);
    wr(OFS_IER, 8'h00);
    wake_evt = 1'b1;
    cyc(1);
    wake_evt = 1'b0;
    cyc(2);
    chk("irq_out", 8'h01, {7'h0, irq_out});
    rd(OFS_ISR, "isr", 8'hc1);
    cyc(2);
    chk("irq_out", 8'h00, {7'h0, irq_out});
    results();
  end
  // Whole run is near 400 clocks; cut off well beyond that
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule // uic_top_tb
`default_nettype wire
